// *** timed_port_pkg.sv ***
package timed_port_pkg;
   localparam int CNT_W    = 16;
   localparam int NUM_CB   = 6;
   localparam int CB_SEL_W = 3;
   localparam int DIV_W    = 8;

   typedef enum logic [2:0] {
      CND_NONE = 3'b001,
      CND_EQ   = 3'b010,
      CND_NEQ  = 3'b100
   } cond_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } state_e;

   localparam logic [CB_SEL_W-1:0] CLKSEL_RST = 3'h0;
   localparam logic [DIV_W-1:0]    DIV_RST    = 8'h00;
   localparam logic                EXT_RST    = 1'h0;
   localparam logic                DIR_RST    = 1'h0;
   localparam logic                OD_RST     = 1'h0;
   localparam cond_e               COND_RST   = CND_NONE;
endpackage

// *** stream_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int DW = 8);
   logic          valid;
   logic          ready;
   logic [DW-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** two_entry_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
   parameter int DW = 8
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Streams
   stream_if.snk     inq,
   stream_if.src     outq
);
   typedef struct packed {
      logic [DW-1:0] d0;
      logic [DW-1:0] d1;
      logic          v0;
      logic          v1;
      logic          rdy;
   } buf_s;

   buf_s buf_r;
   buf_s buf_nxt;
   logic push;
   logic pop;

   // Head slot feeds the output so valid and data come from flops
   always_comb begin
      buf_nxt = buf_r;
      push    = inq.valid & ~buf_r.v1;
      pop     = outq.ready & buf_r.v0;
      if (pop) begin
         buf_nxt.d0 = buf_r.d1;
         buf_nxt.v0 = buf_r.v1;
         buf_nxt.v1 = 1'b0;
      end
      if (push) begin
         if (!buf_nxt.v0) begin
            buf_nxt.d0 = inq.data;
            buf_nxt.v0 = 1'b1;
         end else begin
            buf_nxt.d1 = inq.data;
            buf_nxt.v1 = 1'b1;
         end
      end
      // Ready from a flop so the core sees no logic path
      buf_nxt.rdy = ~buf_nxt.v1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_r     <= '0;
         buf_r.rdy <= 1'b1;
      end else begin
         buf_r <= buf_nxt;
      end
   end

   assign inq.ready  = buf_r.rdy;
   assign outq.valid = buf_r.v0;
   assign outq.data  = buf_r.d0;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_buf_order: assert property (buf_r.v1 |-> buf_r.v0)
      else $error("second slot full with head empty");
endmodule // two_entry_buffer
`default_nettype wire

// *** clock_block.sv ***
`timescale 1ns/1ps
`default_nettype none
module clock_block
   import timed_port_pkg::*;
#(
   parameter bit FIXED = 1'b0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Sources
   input  wire logic             extEvt,
   // Programming
   input  wire logic             cfgLoad,
   input  wire logic             cfgExt,
   input  wire logic [DIV_W-1:0] cfgDiv,
   // Rate
   output logic                  tick
);
   typedef struct packed {
      logic             ext;
      logic [DIV_W-1:0] div;
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } cb_s;

   cb_s  cb_r;
   cb_s  cb_nxt;
   logic evt;

   always_comb begin
      cb_nxt      = cb_r;
      cb_nxt.tick = 1'b0;
      evt = cb_r.ext ? extEvt : 1'b1;
      if (cfgLoad && !FIXED) begin
         cb_nxt.ext = cfgExt;
         cb_nxt.div = cfgDiv;
         cb_nxt.cnt = '0;
      end else if (evt) begin
         if (cb_r.cnt >= cb_r.div) begin
            cb_nxt.cnt  = '0;
            cb_nxt.tick = 1'b1;
         end else begin
            cb_nxt.cnt = cb_r.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cb_r     <= '0;
         cb_r.ext <= EXT_RST;
         cb_r.div <= DIV_RST;
      end else begin
         cb_r <= cb_nxt;
      end
   end

   assign tick = cb_r.tick;

   default clocking dc @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_div_gap: assert property ((cb_r.div != '0 && tick) |=> !tick)
      else $error("divided clock ticked twice in a row");
endmodule // clock_block
`default_nettype wire

// *** timed_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module timed_port
   import timed_port_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                arst_n,
   // Port configuration
   input  wire logic                cfgLoad,
   input  wire logic                cfgOut,
   input  wire logic                cfgOpenDrain,
   input  wire cond_e               cfgCond,
   input  wire logic [W-1:0]        cfgCondVal,
   input  wire logic                cfgStrobeIn,
   input  wire logic                cfgStrobeOut,
   input  wire logic [CB_SEL_W-1:0] cfgClkSel,
   // Clock block programming
   input  wire logic                cbLoad,
   input  wire logic [CB_SEL_W-1:0] cbIdx,
   input  wire logic                cbExt,
   input  wire logic [DIV_W-1:0]    cbDiv,
   // Pin sharing
   input  wire logic [W-1:0]        linkOwn,
   input  wire logic [W-1:0]        narrowOwn,
   // Core output
   input  wire logic                wrValid,
   input  wire logic [W-1:0]        wrData,
   input  wire logic                wrTimed,
   input  wire logic [CNT_W-1:0]    wrTime,
   output logic                     wrReady,
   // Core input
   input  wire logic                rdReady,
   output logic                     rdValid,
   output logic [W-1:0]             rdData,
   // Time
   output logic [CNT_W-1:0]         cntValue,
   output logic [CNT_W-1:0]         stampValue,
   // Pins
   input  wire logic [W-1:0]        pinIn,
   output logic [W-1:0]             pinOut,
   output logic [W-1:0]             pinOe,
   input  wire logic                clkPin,
   input  wire logic                strobeIn,
   output logic                     output_strobe
);
   localparam int TXW = W + 1 + CNT_W;

   typedef struct packed {
      logic [W-1:0]        pinSync1;
      logic [W-1:0]        pinSync2;
      logic                clkSync1;
      logic                clkSync2;
      logic                clkPrev;
      logic                stbSync1;
      logic                stbSync2;
      logic                dirOut;
      logic                od;
      cond_e               cond;
      logic [W-1:0]        condVal;
      logic                stbIn;
      logic                stbOut;
      logic [CB_SEL_W-1:0] clkSel;
      state_e              st;
      logic [CNT_W-1:0]    cnt;
      logic [CNT_W-1:0]    stamp;
      logic [W-1:0]        xfer;
      logic [W-1:0]        pinOut;
      logic [W-1:0]        pinOe;
      logic                strobe;
   } port_s;

   function automatic logic cond_ok(cond_e c, logic [W-1:0] v,
                                    logic [W-1:0] ref_v);
      case (c)
         CND_EQ:  cond_ok = (v == ref_v);
         CND_NEQ: cond_ok = (v != ref_v);
         default: cond_ok = 1'b1;
      endcase
   endfunction

   port_s            state_r;
   port_s            state_nxt;
   logic [NUM_CB-1:0] tickVec;
   logic             tick;
   logic             extRise;
   logic             txPop;
   logic             rxPush;
   logic             busy;
   logic [W-1:0]     own;
   logic [W-1:0]     sample;
   logic             txTimed;
   logic [CNT_W-1:0] txTime;
   logic [W-1:0]     txData;

   stream_if #(.DW(TXW)) txIn ();
   stream_if #(.DW(TXW)) txOut ();
   stream_if #(.DW(W))   rxIn ();
   stream_if #(.DW(W))   rxOut ();

   two_entry_buffer #(.DW(TXW)) u_txq (
      .clk    (clk),
      .arst_n (arst_n),
      .inq    (txIn),
      .outq   (txOut)
   );

   two_entry_buffer #(.DW(W)) u_rxq (
      .clk    (clk),
      .arst_n (arst_n),
      .inq    (rxIn),
      .outq   (rxOut)
   );

   for (genvar g = 0; g < NUM_CB; g++) begin : g_cb
      clock_block #(.FIXED(g == 0)) u_cb (
         .clk     (clk),
         .arst_n  (arst_n),
         .extEvt  (extRise),
         .cfgLoad (cbLoad && (cbIdx == CB_SEL_W'(g))),
         .cfgExt  (cbExt),
         .cfgDiv  (cbDiv),
         .tick    (tickVec[g])
      );
   end

   assign extRise = state_r.clkSync2 & ~state_r.clkPrev;
   assign tick    = tickVec[state_r.clkSel];

   assign txIn.valid  = wrValid;
   assign txIn.data   = {wrTimed, wrTime, wrData};
   assign wrReady     = txIn.ready;
   assign rxOut.ready = rdReady;
   assign rdValid     = rxOut.valid;
   assign rdData      = rxOut.data;
   assign txOut.ready = txPop;
   assign rxIn.valid  = rxPush;
   assign rxIn.data   = sample;

   always_comb begin
      state_nxt = state_r;
      txPop     = 1'b0;
      rxPush    = 1'b0;
      {txTimed, txTime, txData} = txOut.data;
      own = ~(linkOwn | narrowOwn);
      sample = state_r.pinSync2 & own;

      state_nxt.pinSync1 = pinIn;
      state_nxt.pinSync2 = state_r.pinSync1;
      state_nxt.clkSync1 = clkPin;
      state_nxt.clkSync2 = state_r.clkSync1;
      state_nxt.clkPrev  = state_r.clkSync2;
      state_nxt.stbSync1 = strobeIn;
      state_nxt.stbSync2 = state_r.stbSync1;

      if (cfgLoad) begin
         state_nxt.dirOut  = cfgOut;
         state_nxt.od      = cfgOpenDrain;
         state_nxt.cond    = cfgCond;
         state_nxt.condVal = cfgCondVal;
         state_nxt.stbIn   = cfgStrobeIn;
         state_nxt.stbOut  = cfgStrobeOut;
         if (cfgClkSel < CB_SEL_W'(NUM_CB)) begin
            state_nxt.clkSel = cfgClkSel;
         end
      end

      if (tick) begin
         state_nxt.cnt    = state_r.cnt + 16'h0001;
         state_nxt.strobe = 1'b0;
         if (state_r.dirOut) begin
            if (txOut.valid && (!txTimed || txTime == state_r.cnt)) begin
               txPop           = 1'b1;
               state_nxt.xfer  = txData;
               state_nxt.stamp = state_r.cnt;
               state_nxt.strobe = state_r.stbOut;
            end
         end else if (cond_ok(state_r.cond, sample, state_r.condVal)
                      && (!state_r.stbIn || state_r.stbSync2)
                      && rxIn.ready) begin
            rxPush          = 1'b1;
            state_nxt.stamp = state_r.cnt;
            // Fresh config in the same cycle must not be lost
            if (!cfgLoad) begin
               state_nxt.cond = CND_NONE;
            end
         end
      end

      // Waiting for time on a queued output or for a pending input condition
      busy = state_r.dirOut ? (txOut.valid && !txPop)
                            : (state_nxt.cond != CND_NONE);
      case (state_r.st)
         ST_IDLE: begin
            if (busy) begin
               state_nxt.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!busy) begin
               state_nxt.st = ST_IDLE;
            end
         end
         default: begin
            state_nxt.st = ST_IDLE;
         end
      endcase

      state_nxt.pinOut = state_nxt.od ? '0 : state_nxt.xfer;
      state_nxt.pinOe  = state_nxt.dirOut
                         ? (own & (state_nxt.od ? ~state_nxt.xfer : '1))
                         : '0;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r        <= '0;
         state_r.st     <= ST_IDLE;
         state_r.cond   <= COND_RST;
         state_r.clkSel <= CLKSEL_RST;
         state_r.dirOut <= DIR_RST;
         state_r.od     <= OD_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign cntValue      = state_r.cnt;
   assign stampValue    = state_r.stamp;
   assign pinOut        = state_r.pinOut;
   assign pinOe         = state_r.pinOe;
   assign output_strobe = state_r.strobe;

   default clocking dc @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_cnt_wrap: assert property (tick |=> cntValue == $past(cntValue) + 16'h0001)
      else $error("counter did not step on tick");
   a_cnt_hold: assert property (!tick |=> cntValue == $past(cntValue))
      else $error("counter moved without tick");
   a_stamp_capture: assert property (txPop |=> stampValue == $past(cntValue))
      else $error("timestamp not taken on transfer");
   a_timed_match: assert property ((txPop && txTimed) |-> txTime == cntValue)
      else $error("timed output left early");
   a_od_float: assert property (state_r.od |-> (pinOut & pinOe) == '0)
      else $error("open-drain pin driven high");
   a_dir_input: assert property (!state_r.dirOut |-> pinOe == '0)
      else $error("input port drives pins");
   a_shared_quiet: assert property (##1 (pinOe & $past(linkOwn | narrowOwn)) == '0)
      else $error("port drove a pin owned elsewhere");
   a_wr_accept: assert property ((wrValid && wrReady) |=> txOut.valid)
      else $error("accepted write not queued");
   a_cond_sample: assert property (rxPush |-> cond_ok(state_r.cond, sample, state_r.condVal))
      else $error("sample taken before condition met");
   a_strobe_cause: assert property ($rose(output_strobe) |-> $past(txPop))
      else $error("output strobe without transfer");

   c_timed_out: cover property (txPop && txTimed);
   c_cond_in: cover property (rxPush && state_r.cond == CND_EQ);
   c_tx_full: cover property (wrValid && !wrReady);
   c_ext_clock: cover property (tick && state_r.clkSel != CLKSEL_RST);
   c_wait_done: cover property (state_r.st == ST_WAIT ##1 state_r.st == ST_IDLE);
endmodule // timed_port
`default_nettype wire

// *** ext_hw.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_hw #(
   parameter int W = 8
) (
   // Clock
   input  wire logic         clk,
   // Pins
   input  wire logic [W-1:0] pinOut,
   input  wire logic [W-1:0] pinOe,
   output logic [W-1:0]      pinIn,
   output logic              clkPin,
   output logic              strobeIn,
   // Control
   input  wire logic [W-1:0] drvVal,
   input  wire logic         drvStb,
   input  wire logic [3:0]   clkHalf
);
   logic [3:0] n;

   assign strobeIn = drvStb;
   // Port wins where enabled; pull-down is drvVal zero
   assign pinIn = (pinOe & pinOut) | (~pinOe & drvVal);

   // Clock parks low while clkHalf is zero
   always @(posedge clk) begin
      if (clkHalf == 4'h0) begin
         n <= 4'h0;
         clkPin <= 1'b0;
      end else if (n + 4'h1 >= clkHalf) begin
         n <= 4'h0;
         clkPin <= ~clkPin;
      end else begin
         n <= n + 4'h1;
      end
   end
endmodule // ext_hw
`default_nettype wire

// *** timed_io_port_with_clock_blocks_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module timed_io_port_with_clock_blocks_test;
   import timed_port_pkg::*;
   localparam int W = 8;
   logic         clk, arst_n, cfgLoad, cfgOut, cfgOpenDrain, cfgStrobeIn;
   logic         cfgStrobeOut, cbLoad, cbExt, wrValid, wrTimed, wrReady;
   logic         rdReady, rdValid, clkPin, strobeIn, output_strobe, drvStb;
   cond_e        cfgCond;
   logic [W-1:0] cfgCondVal, linkOwn, narrowOwn, wrData, rdData, pinIn;
   logic [W-1:0] pinOut, pinOe, drvVal, own, v, r;
   logic [2:0]   cfgClkSel, cbIdx;
   logic [7:0]   cbDiv;
   logic [3:0]   clkHalf;
   logic [15:0]  wrTime, cntValue, stampValue, lastStamp, c0;
   int           num_errors, comparisons, seed, k;
   int           expQ[$], expT[$];

   timed_port #(.W(W)) u_dut (.clk, .arst_n, .cfgLoad, .cfgOut,
      .cfgOpenDrain, .cfgCond, .cfgCondVal, .cfgStrobeIn, .cfgStrobeOut,
      .cfgClkSel, .cbLoad, .cbIdx, .cbExt, .cbDiv, .linkOwn, .narrowOwn,
      .wrValid, .wrData, .wrTimed, .wrTime, .wrReady, .rdReady, .rdValid,
      .rdData, .cntValue, .stampValue, .pinIn, .pinOut, .pinOe, .clkPin,
      .strobeIn, .output_strobe);
   ext_hw #(.W(W)) u_ext (.clk, .pinOut, .pinOe, .pinIn, .clkPin,
      .strobeIn, .drvVal, .drvStb, .clkHalf);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic cfg(input logic o, input logic d, input cond_e c,
                      input logic [W-1:0] cv, input logic si,
                      input logic so, input logic [2:0] s);
      cfgOut <= o;
      cfgOpenDrain <= d;
      cfgCond <= c;
      cfgCondVal <= cv;
      cfgStrobeIn <= si;
      cfgStrobeOut <= so;
      cfgClkSel <= s;
      cfgLoad <= 1'b1;
      @(posedge clk);
      cfgLoad <= 1'b0;
      @(posedge clk);
   endtask

   task automatic cb(input logic [2:0] i, input logic [7:0] dv);
      cbIdx <= i;
      cbExt <= 1'b1;
      cbDiv <= dv;
      cbLoad <= 1'b1;
      @(posedge clk);
      cbLoad <= 1'b0;
      @(posedge clk);
   endtask

   // Request held until wrReady is seen high at an edge
   task automatic wr(input logic [W-1:0] d, input logic t,
                     input logic [15:0] tm);
      wrValid <= 1'b1;
      wrData <= d;
      wrTimed <= t;
      wrTime <= tm;
      @(negedge clk);
      for (k = 0; k < 50 && wrReady !== 1'b1; k++) @(negedge clk);
      @(posedge clk);
      wrValid <= 1'b0;
      expQ.push_back(int'(d));
      expT.push_back(t ? int'(tm) : -1);
      @(posedge clk);
   endtask

   task automatic flush();
      rdReady <= 1'b1;
      repeat (8) @(posedge clk);
      rdReady <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic drain();
      while (expQ.size() > 0) @(posedge clk);
   endtask

   // Bench model of every output transfer
   always @(negedge clk) begin
      own = ~(linkOwn | narrowOwn);
      if (cfgOut && expQ.size() > 0 && stampValue !== lastStamp) begin
         v = W'(expQ.pop_front());
         chk(pinOe, cfgOpenDrain ? ~v & own : own);
         chk(pinOut & own, cfgOpenDrain ? 8'h00 : v & own);
         chk(cntValue, stampValue + 16'h0001);
         if (expT[0] >= 0) chk(stampValue, 16'(expT[0]));
         if (cfgStrobeOut) chk(output_strobe, 1'b1);
         void'(expT.pop_front());
      end
      lastStamp = stampValue;
   end

   // Longest leg is the wait for the counter to near its wrap
   initial begin
      #(80000 * 50);
      num_errors++;
      wrap_up();
   end

   initial begin
      seed = 44550;
      arst_n = 1'b0;
      cfgCond = CND_NONE;
      {cfgLoad, cfgOut, cfgOpenDrain, cfgStrobeIn, cfgStrobeOut, cbLoad,
       cbExt, wrValid, wrTimed, rdReady, drvStb, cfgCondVal, linkOwn,
       narrowOwn, wrData, drvVal, cfgClkSel, cbIdx, cbDiv, clkHalf,
       wrTime} = '0;
      repeat (20) @(posedge clk);
      chk({wrReady, rdValid, pinOe, cntValue}, 32'h0200_0000);
      arst_n <= 1'b1;
      // First tick of block zero lands one edge after release
      @(negedge clk);
      @(negedge clk);
      chk(cntValue, 16'h0000);
      c0 = cntValue;
      repeat (10) @(negedge clk);
      chk(cntValue - c0, 16'h000a);
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         linkOwn <= (i >= 2) ? 8'h81 : 8'h00;
         narrowOwn <= (i >= 4) ? 8'h3c : 8'h00;
         cfg(1'b1, i[0], CND_NONE, 8'h00, 1'b0, 1'b1, 3'h0);
         wr(W'($random(seed)), i == 3, cntValue + 16'h0028);
         drain();
      end
      linkOwn <= 8'h00;
      narrowOwn <= 8'h00;
      @(negedge clk);
      while (cntValue < 16'hffe0) @(negedge clk);
      c0 = cntValue + 16'h0030;
      @(posedge clk);
      wr(8'h5a, 1'b1, c0);
      drain();
      // Input mode with strobe low keeps the queue from draining
      cfg(1'b0, 1'b0, CND_NONE, 8'h00, 1'b1, 1'b0, 3'h0);
      wr(8'ha5, 1'b0, 16'h0000);
      wr(8'h3c, 1'b0, 16'h0000);
      @(negedge clk);
      chk(wrReady, 1'b0);
      @(posedge clk);
      wrValid <= 1'b1;
      wrData <= 8'hff;
      @(posedge clk);
      wrValid <= 1'b0;
      @(posedge clk);
      cfg(1'b1, 1'b0, CND_NONE, 8'h00, 1'b0, 1'b0, 3'h0);
      drain();
      repeat (4) @(negedge clk);
      chk(pinOut, 8'h3c);
      @(posedge clk);
      drvVal <= 8'h11;
      cfg(1'b0, 1'b0, CND_EQ, 8'h77, 1'b0, 1'b0, 3'h0);
      flush();
      chk(rdValid, 1'b0);
      @(posedge clk);
      drvVal <= 8'h77;
      for (k = 0; k < 100 && rdValid !== 1'b1; k++) @(negedge clk);
      chk(rdData, 8'h77);
      @(posedge clk);
      narrowOwn <= 8'h0f;
      cfg(1'b0, 1'b0, CND_NONE, 8'h00, 1'b1, 1'b0, 3'h0);
      flush();
      chk(rdValid, 1'b0);
      @(posedge clk);
      r = W'($random(seed));
      drvVal <= r;
      drvStb <= 1'b1;
      for (k = 0; k < 100 && rdValid !== 1'b1; k++) @(negedge clk);
      chk(rdData, r & 8'hf0);
      @(posedge clk);
      drvStb <= 1'b0;
      narrowOwn <= 8'h00;
      clkHalf <= 4'h4;
      cb(3'h0, 8'h03);
      @(negedge clk);
      c0 = cntValue;
      repeat (20) @(negedge clk);
      chk(cntValue - c0, 16'h0014);
      @(posedge clk);
      cfg(1'b0, 1'b0, CND_NONE, 8'h00, 1'b1, 1'b0, 3'h1);
      for (int d = 0; d < 2; d++) begin
         cb(3'h1, 8'(d));
         @(negedge clk);
         c0 = cntValue;
         repeat (160) @(negedge clk);
         k = int'(cntValue - c0) - 20 / (d + 1);
         chk(k >= -1 && k <= 1, 1'b1);
         @(posedge clk);
      end
      clkHalf <= 4'h0;
      wrap_up();
   end
endmodule // timed_io_port_with_clock_blocks_test
`default_nettype wire
